// file: shared/lsc_map.vh
// Constants for the module low-speed control block: memory map, bits, timing.
// Assumes a 100 MHz core clock; included by bare name from the design files.
`ifndef LSC_MAP_VH
`define LSC_MAP_VH

// Core clock rate
`define LSC_CLK_MHZ 100

// Least low time on the reset pin that is taken as a reset, and derived cycles
`define LSC_RESET_MIN_NS 10000
`define LSC_RESET_MIN_CYC ((`LSC_RESET_MIN_NS * `LSC_CLK_MHZ + 999) / 1000)
// Longest time from reset release to the completion interrupt, and cycles
`define LSC_INIT_NS 20000
`define LSC_INIT_CYC ((`LSC_INIT_NS * `LSC_CLK_MHZ) / 1000)
`define LSC_CNT_W 11

// 2-wire bus device address (7 bits)
`define LSC_DEV_ADDR 7'h50

// Memory map byte offsets
`define LSC_OFS_IDENT 8'h00
`define LSC_OFS_STATUS 8'h01
`define LSC_OFS_FLAGS 8'h02
`define LSC_OFS_MASK 8'h03
`define LSC_OFS_CTRL 8'h04

// Field positions
`define LSC_STATUS_NOT_READY 0
`define LSC_STATUS_LOW_POWER 1
`define LSC_FLAG_RESET_DONE 0
`define LSC_FLAG_FAULT 1
`define LSC_CTRL_FORCE_LP 0

// Reset values
`define LSC_MASK_RST 8'h00
`define LSC_CTRL_RST 8'h00
`define LSC_FLAGS_RST 8'h00

`endif

// file: hw/pin_sync.v
// Two flip-flop synchroniser for a group of pins.
// Assumes inputs arrive from outside the clk domain; only stage two is read.
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input wire clk,
  input wire rstn,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage feeds only the second; reset to the idle level
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync_out = sync_reg;

endmodule // pin_sync

`default_nettype wire

// file: hw/module_low_speed_control.v
// Low-speed control logic of a pluggable transceiver: select, reset, low power,
// presence, interrupt and a 2-wire bus slave onto a small management map.
// Assumes host pull-ups on the open-drain pins and pins sampled by clk.
// Summary of operation
// - Seven low-speed pins are served: select, clock, data, reset, low power, presence and interrupt.
// - Bus commands are answered only while module_select_n is held low.
// - Clock and data lines carry bus transfers that read and write the management map.
// - A module_reset_n low longer than the least pulse restores every setting to its default.
// - At reset completion the not-ready bit is cleared and interrupt_n is asserted.
// - After power-up the completion interrupt is raised without any reset pulse.
// - The low_power_select level limits the module's maximum power.
// - The presence_n pin is tied to ground while the module is inserted.
// - interrupt_n is pulled low to flag a fault or a critical status.
// - interrupt_n is only ever pulled low; the host supplies the pull-up.
`timescale 1ns/1ns
`default_nettype none
`include "lsc_map.vh"

module module_low_speed_control #(
  parameter [7:0] IDENT_CODE = 8'h5a // Arbitrary identifier value
) (
  input wire clk,
  input wire rstn,
  input wire module_select_n,
  input wire module_reset_n,
  input wire low_power_select,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe_n,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  output wire presence_out,
  output wire presence_oe_n,
  output wire interrupt_out,
  output wire interrupt_oe_n,
  input wire fault_event,
  output reg low_power_mode,
  output wire data_not_ready
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_AACK = 3'd2;
  localparam [2:0] ST_WRITE = 3'd3;
  localparam [2:0] ST_WACK = 3'd4;
  localparam [2:0] ST_READ = 3'd5;
  localparam [2:0] ST_RACK = 3'd6;

  wire scl_s;
  wire sda_s;
  wire sel_n_s;
  wire rst_n_s;
  wire lp_s;
  reg scl_d_reg;
  reg sda_d_reg;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;

  // Bus pins idle high, control pins default to deselected, not reset, low power
  pin_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_link_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in({scl_in, sda_in}),
    .pin_sync_out({scl_s, sda_s})
  );
  pin_sync #(.WIDTH(3), .RST_VAL(3'b111)) u_ctrl_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in({module_select_n, module_reset_n, low_power_select}),
    .pin_sync_out({sel_n_s, rst_n_s, lp_s})
  );

  // Delayed copies for edge finding, read from the second stage only
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Reset pin filter and completion sequencer
  reg [`LSC_CNT_W-1:0] low_cnt_reg;
  reg [`LSC_CNT_W-1:0] init_cnt_reg;
  reg reset_taken_reg;
  reg init_busy_reg;
  reg not_ready_reg;
  reg init_done_reg;
  wire soft_reset;

  // Soft reset fires once the low pulse has lasted the least length
  assign soft_reset = ~rst_n_s & ~reset_taken_reg & (low_cnt_reg == `LSC_RESET_MIN_CYC - 1);

  // Power-up starts the init countdown with no reset pulse needed
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_reg <= {`LSC_CNT_W{1'b0}};
      init_cnt_reg <= {`LSC_CNT_W{1'b0}};
      reset_taken_reg <= 1'b0;
      init_busy_reg <= 1'b1;
      not_ready_reg <= 1'b1;
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= 1'b0;
      if (!rst_n_s) begin
        if (!reset_taken_reg) begin
          low_cnt_reg <= low_cnt_reg + {{(`LSC_CNT_W-1){1'b0}}, 1'b1};
        end
        if (soft_reset) begin
          reset_taken_reg <= 1'b1;
          not_ready_reg <= 1'b1;
          init_busy_reg <= 1'b0;
          init_cnt_reg <= {`LSC_CNT_W{1'b0}};
        end
      end else begin
        low_cnt_reg <= {`LSC_CNT_W{1'b0}};
        // Short glitches never set reset_taken, so they are ignored
        if (reset_taken_reg) begin
          reset_taken_reg <= 1'b0;
          init_busy_reg <= 1'b1;
          init_cnt_reg <= {`LSC_CNT_W{1'b0}};
        end else if (init_busy_reg) begin
          if (init_cnt_reg == `LSC_INIT_CYC - 1) begin
            init_busy_reg <= 1'b0;
            not_ready_reg <= 1'b0;
            init_done_reg <= 1'b1;
          end else begin
            init_cnt_reg <= init_cnt_reg + {{(`LSC_CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  end

  assign data_not_ready = not_ready_reg;

  // Bus slave state
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg rw_reg;
  reg first_reg;
  reg nack_reg;
  reg sda_drive_reg;
  reg wr_pulse_reg;
  reg [7:0] wr_addr_reg;
  reg [7:0] wr_data_reg;
  reg rd_clr_reg;
  reg [7:0] flags_reg;
  reg [7:0] mask_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] rd_data;

  // Read data for the byte at the pointer
  always @* begin
    if (ptr_reg == `LSC_OFS_IDENT) begin
      rd_data = IDENT_CODE;
    end else if (ptr_reg == `LSC_OFS_STATUS) begin
      rd_data = 8'h00;
      rd_data[`LSC_STATUS_NOT_READY] = not_ready_reg;
      rd_data[`LSC_STATUS_LOW_POWER] = low_power_mode;
    end else if (ptr_reg == `LSC_OFS_FLAGS) begin
      rd_data = flags_reg;
    end else if (ptr_reg == `LSC_OFS_MASK) begin
      rd_data = mask_reg;
    end else if (ptr_reg == `LSC_OFS_CTRL) begin
      rd_data = ctrl_reg;
    end else begin
      rd_data = 8'h00;
    end
  end

  // Byte-level slave; deselect or stop drops it to idle and frees the data line
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_drive_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      rd_clr_reg <= 1'b0;
    end else begin
      wr_pulse_reg <= 1'b0;
      rd_clr_reg <= 1'b0;
      if (sel_n_s) begin
        state_reg <= ST_IDLE;
        sda_drive_reg <= 1'b0;
      end else if (bus_start) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_drive_reg <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        sda_drive_reg <= 1'b0;
      end else if (scl_rise) begin
        case (state_reg)
          ST_ADDR, ST_WRITE: begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          ST_READ: begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          ST_RACK: begin
            nack_reg <= sda_s;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == `LSC_DEV_ADDR) begin
                rw_reg <= shift_reg[0];
                sda_drive_reg <= 1'b1;
                state_reg <= ST_AACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              shift_reg <= rd_data;
              sda_drive_reg <= ~rd_data[7];
              rd_clr_reg <= (ptr_reg == `LSC_OFS_FLAGS);
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_READ;
            end else begin
              sda_drive_reg <= 1'b0;
              first_reg <= 1'b1;
              state_reg <= ST_WRITE;
            end
          end
          ST_WRITE: begin
            if (bit_cnt_reg == 4'h8) begin
              // First byte sets the pointer, later bytes store and advance
              if (first_reg) begin
                ptr_reg <= shift_reg;
                first_reg <= 1'b0;
              end else begin
                wr_pulse_reg <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
              sda_drive_reg <= 1'b1;
              state_reg <= ST_WACK;
            end
          end
          ST_WACK: begin
            sda_drive_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_WRITE;
          end
          ST_READ: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_drive_reg <= 1'b0;
              state_reg <= ST_RACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_drive_reg <= ~shift_reg[6];
            end
          end
          ST_RACK: begin
            // A not-acknowledge from the host ends the read
            if (nack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              bit_cnt_reg <= 4'h0;
              shift_reg <= rd_data;
              sda_drive_reg <= ~rd_data[7];
              rd_clr_reg <= (ptr_reg == `LSC_OFS_FLAGS);
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_READ;
            end
          end
          default: begin
            sda_drive_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Writable settings; a taken reset pulse restores defaults
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= `LSC_MASK_RST;
      ctrl_reg <= `LSC_CTRL_RST;
    end else if (soft_reset) begin
      mask_reg <= `LSC_MASK_RST;
      ctrl_reg <= `LSC_CTRL_RST;
    end else if (wr_pulse_reg) begin
      if (wr_addr_reg == `LSC_OFS_MASK) begin
        mask_reg <= wr_data_reg;
      end else if (wr_addr_reg == `LSC_OFS_CTRL) begin
        ctrl_reg <= wr_data_reg;
      end
    end
  end

  // Sticky flags clear on read; an event in the clearing cycle still lands
  reg [7:0] flag_set;
  reg [7:0] flags_next;
  always @* begin
    flag_set = 8'h00;
    flag_set[`LSC_FLAG_RESET_DONE] = init_done_reg;
    flag_set[`LSC_FLAG_FAULT] = fault_event;
    flags_next = flags_reg;
    if (rd_clr_reg) begin
      flags_next = 8'h00;
    end
    flags_next = flags_next | flag_set;
    if (soft_reset) begin
      flags_next = `LSC_FLAGS_RST;
    end
  end

  // Registered pin levels: interrupt from unmasked flags, power limit from pin or force bit
  reg irq_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= `LSC_FLAGS_RST;
      irq_reg <= 1'b0;
      low_power_mode <= 1'b1;
    end else begin
      flags_reg <= flags_next;
      irq_reg <= |(flags_reg & ~mask_reg);
      low_power_mode <= lp_s | ctrl_reg[`LSC_CTRL_FORCE_LP];
    end
  end

  // Open-drain pins only ever pull low; host pull-ups make the high level
  assign interrupt_out = 1'b0;
  assign interrupt_oe_n = ~irq_reg;
  assign sda_out = 1'b0;
  assign sda_oe_n = ~sda_drive_reg;
  // No clock stretching, so the clock line is never driven
  assign scl_out = 1'b0;
  assign scl_oe_n = 1'b1;
  // Presence is a hard tie to ground while inserted
  assign presence_out = 1'b0;
  assign presence_oe_n = 1'b0;

endmodule // module_low_speed_control

`default_nettype wire

// file: bench/module_low_speed_control_properties.sv
// Checker of the low-speed control block, watching its top-level pins.
// Assumes the block's clk and rstn and the timing constants of lsc_map.vh.
`timescale 1ns/1ns
`default_nettype none
`include "lsc_map.vh"
module module_low_speed_control_properties (
  input wire clk,
  input wire rstn,
  input wire module_select_n,
  input wire module_reset_n,
  input wire low_power_select,
  input wire scl_out,
  input wire scl_oe_n,
  input wire sda_out,
  input wire sda_oe_n,
  input wire presence_out,
  input wire presence_oe_n,
  input wire interrupt_out,
  input wire interrupt_oe_n,
  input wire fault_event,
  input wire low_power_mode,
  input wire data_not_ready
);
  localparam int RMIN = `LSC_RESET_MIN_CYC;
  localparam int INIT = `LSC_INIT_CYC;
  int low_cnt;
  int busy_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Run lengths; loose bounds absorb the two-stage pin sync
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= 0;
      busy_cnt <= 0;
    end else begin
      low_cnt <= module_reset_n ? 0 : low_cnt + 1;
      busy_cnt <= (data_not_ready && module_reset_n) ? busy_cnt + 1 : 0;
    end
  end
  presence_tied_a: assert property (!presence_oe_n && !presence_out)
    else $error("presence not tied low");
  open_drain_a: assert property (!interrupt_out && !sda_out && !scl_out && scl_oe_n)
    else $error("pin driven high");
  desel_quiet_a: assert property (module_select_n [*6] |-> sda_oe_n)
    else $error("data driven while deselected");
  ack_selected_a: assert property ($fell(sda_oe_n) |-> !$past(module_select_n, 3))
    else $error("answer without select");
  lp_pin_a: assert property (low_power_select [*4] |-> low_power_mode)
    else $error("power limit missing");
  reset_len_a: assert property ($rose(data_not_ready) |-> low_cnt >= RMIN)
    else $error("short pulse taken as reset");
  init_len_a: assert property ($fell(data_not_ready) |-> $past(busy_cnt) >= INIT - 4)
    else $error("init too short");
  init_max_a: assert property (busy_cnt <= INIT + 6)
    else $error("init too long");
  ready_intr_a: assert property ($fell(data_not_ready) |-> ##[0:3] !interrupt_oe_n)
    else $error("no completion interrupt");
  fault_intr_a: assert property (fault_event |-> ##[1:4] !interrupt_oe_n)
    else $error("no fault interrupt");
  cover property ($fell(data_not_ready));
  cover property (fault_event ##[1:4] !interrupt_oe_n);
  cover property ($fell(sda_oe_n));
endmodule // module_low_speed_control_properties
`default_nettype wire

// file: bench/host_bus_model.sv
// Host controller model: masters the 2-wire bus, only ever pulling data low.
// Assumes a pull-up on data; the bus clock stands high between frames.
`timescale 1ns/1ns
`default_nettype none
`include "lsc_map.vh"
module host_bus_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start, also a repeated start from a low clock
  task automatic start;
    sda_low = 1'b0;
    #31 scl = 1'b1;
    #31 sda_low = 1'b1;
    #31 scl = 1'b0;
    #32;
  endtask
  task automatic stop;
    sda_low = 1'b1;
    #31 scl = 1'b1;
    #31 sda_low = 1'b0;
    #62;
  endtask
  // One bit at 125 ns; b=1 releases the line so the module may answer
  task automatic bit_x(input logic b, output logic r);
    sda_low = ~b;
    #31 scl = 1'b1;
    // Falling clock kept off the core clock's rising edge
    #31 r = sda;
    #31 scl = 1'b0;
    #32;
  endtask
  // Byte out MSB first; ok drops on a missing acknowledge
  task automatic send(input logic [7:0] d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(d[i], a);
    bit_x(1'b1, a);
    ok = ok & ~a;
  endtask
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start;
    send({`LSC_DEV_ADDR, 1'b0}, ok);
    send(ofs, ok);
    send(d, ok);
    stop;
  endtask
  // Pointer write, repeated start, one byte read, then not-acknowledge
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic a;
    ok = 1'b1;
    start;
    send({`LSC_DEV_ADDR, 1'b0}, ok);
    send(ofs, ok);
    start;
    send({`LSC_DEV_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(1'b1, a);
    stop;
  endtask
endmodule // host_bus_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the low-speed control block with a host bus model.
// Assumes lsc_map.vh timing; the checker is bound at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
`include "lsc_map.vh"
module tb_top;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic module_select_n = 1'b1;
  logic module_reset_n = 1'b1;
  logic low_power_select = 1'b0;
  logic fault_event = 1'b0;
  logic ok;
  logic [7:0] rd;
  int n_mismatch = 0;
  int compares = 0;
  wire scl, sda_low, scl_out, scl_oe_n, sda_out, sda_oe_n, presence_out, presence_oe_n;
  wire interrupt_out, interrupt_oe_n, low_power_mode, data_not_ready;
  wire sda = ~(sda_low | ~sda_oe_n);
  module_low_speed_control #(.IDENT_CODE(ID)) module_low_speed_control_i (
    .clk(clk), .rstn(rstn), .module_select_n(module_select_n), .module_reset_n(module_reset_n),
    .low_power_select(low_power_select), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .presence_out(presence_out),
    .presence_oe_n(presence_oe_n), .interrupt_out(interrupt_out), .interrupt_oe_n(interrupt_oe_n),
    .fault_event(fault_event), .low_power_mode(low_power_mode), .data_not_ready(data_not_ready));
  host_bus_model host_bus_model_i (.scl(scl), .sda_low(sda_low), .sda(sda));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp);
    cyc(1);
    host_bus_model_i.read_reg(ofs, rd, ok);
    chb(ok, 1'b1);
    chk(rd, exp);
  endtask
  // Bounded wait for not-ready to fall, then the completion interrupt
  task automatic wait_ready;
    int n;
    n = 0;
    while (data_not_ready === 1'b1 && n < 2200) begin
      cyc(1);
      n++;
    end
    chb(data_not_ready, 1'b0);
    chb(n >= `LSC_INIT_CYC - 5, 1'b1);
    cyc(3);
    chb(interrupt_oe_n, 1'b0);
  endtask
  task automatic t_power_up;
    chb(data_not_ready, 1'b1);
    wait_ready;
    chb(presence_oe_n, 1'b0);
    rdc(`LSC_OFS_STATUS, 8'h00);
    rdc(`LSC_OFS_FLAGS, 8'h01);
    cyc(4);
    chb(interrupt_oe_n, 1'b1);
  endtask
  // Read-only ident, unmapped byte, then a deselected read sees only the pull-up
  task automatic t_map_select;
    rdc(`LSC_OFS_IDENT, ID);
    cyc(1);
    host_bus_model_i.write_reg(`LSC_OFS_IDENT, 8'hff, ok);
    rdc(`LSC_OFS_IDENT, ID);
    rdc(8'h7f, 8'h00);
    cyc(1);
    module_select_n = 1'b1;
    host_bus_model_i.read_reg(`LSC_OFS_IDENT, rd, ok);
    chb(ok, 1'b0);
    chk(rd, 8'hff);
    cyc(1);
    module_select_n = 1'b0;
    cyc(4);
  endtask
  task automatic t_low_power;
    low_power_select = 1'b1;
    cyc(5);
    chb(low_power_mode, 1'b1);
    rdc(`LSC_OFS_STATUS, 8'h02);
    cyc(1);
    low_power_select = 1'b0;
    cyc(5);
    chb(low_power_mode, 1'b0);
    host_bus_model_i.write_reg(`LSC_OFS_CTRL, 8'h01, ok);
    cyc(3);
    chb(low_power_mode, 1'b1);
    rdc(`LSC_OFS_CTRL, 8'h01);
  endtask
  task automatic t_fault;
    cyc(1);
    fault_event = 1'b1;
    cyc(1);
    fault_event = 1'b0;
    cyc(3);
    chb(interrupt_oe_n, 1'b0);
    rdc(`LSC_OFS_FLAGS, 8'h02);
    cyc(4);
    chb(interrupt_oe_n, 1'b1);
  endtask
  // Pulse just under the minimum is ignored; a long one restores defaults
  task automatic t_soft_reset;
    cyc(1);
    host_bus_model_i.write_reg(`LSC_OFS_MASK, 8'h02, ok);
    chb(ok, 1'b1);
    rdc(`LSC_OFS_MASK, 8'h02);
    cyc(1);
    module_reset_n = 1'b0;
    cyc(`LSC_RESET_MIN_CYC - 20);
    module_reset_n = 1'b1;
    cyc(5);
    chb(data_not_ready, 1'b0);
    module_reset_n = 1'b0;
    cyc(`LSC_RESET_MIN_CYC + 10);
    chb(data_not_ready, 1'b1);
    module_reset_n = 1'b1;
    wait_ready;
    chb(low_power_mode, 1'b0);
    rdc(`LSC_OFS_CTRL, 8'h00);
    rdc(`LSC_OFS_FLAGS, 8'h01);
    rdc(`LSC_OFS_MASK, 8'h00);
  endtask
  task automatic end_of_test;
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    rstn = 1'b1;
    module_select_n = 1'b0;
    t_power_up;
    t_map_select;
    t_low_power;
    t_fault;
    t_soft_reset;
    end_of_test;
  end
  // Watchdog well past the roughly 13.5k cycles the sequence needs
  initial begin
    #400_000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test;
  end
endmodule // tb_top
bind module_low_speed_control module_low_speed_control_properties module_low_speed_control_properties_i (
  .clk(clk), .rstn(rstn), .module_select_n(module_select_n), .module_reset_n(module_reset_n),
  .low_power_select(low_power_select), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .presence_out(presence_out), .presence_oe_n(presence_oe_n), .interrupt_out(interrupt_out),
  .interrupt_oe_n(interrupt_oe_n), .fault_event(fault_event), .low_power_mode(low_power_mode),
  .data_not_ready(data_not_ready));
`default_nettype wire
